// ===== hw/bridge_option_regs.sv
// Bridge option register, its reset sources and the logic it steers
//
// Summary of operation
// R01: In active mode a set filter bit declares open load after one retry, a clear one after 40 ms.
// R02: The filter selection only acts while the bridge is active; in off state detection ignores it.
// R03: Slew select high gives the fast output slew rate, low the slow one.
// R04: Spread enable high dithers the internal state machine clock.
// R05: Spread enable low gives the state machine a constant clock.
// R06: Power-up and software reset load 0x11 into the option register.
// R07: Each edge of the disable or active-low enable pin makes an enable/disable reset, option register untouched.
// R08: Setting the reset bit of the configuration register by serial write performs a software reset.
// R09: Reads clear the affected bits of registers with a read reset; the option register ignores reads.
// R10: Setting the diagnosis transfer clear bit resets the registers that list it; here diag_copy stays low in undervoltage, so no reset then.
// R11: Setting the diagnosis history clear bit resets the registers that list it.
// R12: Writing zero to the transfer clear bit copies first diagnosis errors to the second, blocked in undervoltage.
// R13: Unspecified option bits ignore writes and read zero.
// R14: The option register is written and read only by its dedicated commands, one frame each.
`timescale 1ns/1ps
`include "bridge_option_consts.svh"
module bridge_option_regs
  import bridge_option_pkg::*;
(
  // Clock and reset (reset is the power-up reset)
  input wire logic ref_clk,
  input wire logic rst,
  // Decoded serial commands
  input wire logic opt_write_cmd,
  input wire logic [7:0] opt_write_data,
  input wire logic opt_read_cmd,
  input wire logic software_reset_command,
  input wire logic diag_transfer_clear,
  input wire logic diag_history_clear,
  input wire logic read_access_reset,
  // Pins and supply state
  input wire logic stage_disable_pin,
  input wire logic stage_enable_low_pin,
  input wire logic supply_undervoltage,
  // Bridge state and open load sensing
  input wire logic bridge_active,
  input wire logic open_load_sense,
  // First diagnosis latched errors
  input wire logic [3:0] first_diag_errors,
  // Read path
  output logic [7:0] opt_read_data,
  output logic opt_read_valid,
  // Steering outputs
  output logic slew_fast,
  output logic spread_active,
  output logic sm_tick,
  output logic open_load_flag,
  // Resets and diagnosis transfer
  output logic stage_toggle_reset,
  output logic diag_copy,
  output logic [3:0] second_diag_q,
  output logic diag_history_reset,
  output logic read_clear_reset
);
  localparam int unsigned OL_CYC = `OL_FILTER_CYCLES;

  clock_dither_if dc ();

  opt_reg_t opt_q, opt_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic slew_q, slew_d, spread_q, spread_d, tick_q;
  logic dis_q, abe_q, pins_seen_q, pins_seen_d;
  logic dis_d, abe_d, tick_d;
  logic tog_q, tog_d;
  logic copy_q, copy_d, hclr_q, hclr_d, rclr_q, rclr_d;
  logic [3:0] diag2_q, diag2_d;
  ol_state_t ol_q, ol_d;
  logic [22:0] olcnt_q, olcnt_d;
  logic olflag_q, olflag_d;

  sm_tick_gen u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .dc(dc)
  );

  assign dc.dither_on = opt_q[`OPT_BIT_SPREAD];

  // Option register and its effects
  always_comb begin
    opt_d = opt_q;
    if (software_reset_command) begin
      opt_d = `OPT_RESET_VAL; // see R06 see R08
    end else if (opt_write_cmd) begin
      opt_d = opt_write_data & `OPT_WRITE_MASK; // see R13 see R14
    end
    // Edge resets and reads leave the option register alone
    rdata_d = rdata_q; // see R07 see R09
    rvalid_d = opt_read_cmd;
    if (opt_read_cmd) begin
      rdata_d = opt_q; // see R14
    end
    slew_d = opt_q[`OPT_BIT_SLEW]; // see R03
    spread_d = opt_q[`OPT_BIT_SPREAD];
    // Retimed so the output stands straight from a flop
    tick_d = dc.tick;
  end

  // Reset sources toward the other registers
  always_comb begin
    // First sample after reset only primes the detector, so the enable pin's idle high gives no false edge
    pins_seen_d = 1'b1;
    dis_d = stage_disable_pin;
    abe_d = stage_enable_low_pin;
    tog_d = pins_seen_q && ((stage_disable_pin != dis_q) || (stage_enable_low_pin != abe_q)); // see R07
    hclr_d = diag_history_clear; // see R11
    rclr_d = read_access_reset; // see R09
    // Transfer is blocked during undervoltage
    copy_d = diag_transfer_clear && !supply_undervoltage; // see R10 see R12
    // Software reset and history clear win over a transfer in the same cycle
    diag2_d = diag2_q;
    if (software_reset_command || diag_history_clear) begin
      diag2_d = `DIAG_ALL_ONES; // see R11
    end else if (copy_d) begin
      diag2_d = first_diag_errors; // see R12
    end
  end

  // Open load filter
  // Counter width covers 40 ms at clocks up to about 209 MHz; a faster clock would need a wider counter
  always_comb begin
    ol_d = ol_q;
    olcnt_d = olcnt_q;
    olflag_d = olflag_q;
    if (!bridge_active) begin
      // Off state: filter bit is a don't care, detection is immediate
      ol_d = OL_IDLE; // see R02
      olcnt_d = '0;
      olflag_d = open_load_sense;
    end else begin
      unique case (ol_q)
        OL_IDLE: begin
          olcnt_d = '0;
          olflag_d = 1'b0;
          if (open_load_sense) begin
            ol_d = OL_RETRY;
          end
        end
        OL_RETRY: begin
          if (!open_load_sense) begin
            ol_d = OL_IDLE;
          end else if (opt_q[`OPT_BIT_OLFILT]) begin
            // Second sighting counts as the one retry
            ol_d = OL_FLAGGED; // see R01
            olflag_d = 1'b1;
          end else if (olcnt_d >= 23'(OL_CYC - 1)) begin
            ol_d = OL_FLAGGED; // see R01
            olflag_d = 1'b1;
          end else begin
            olcnt_d = olcnt_q + 23'h1;
          end
        end
        OL_FLAGGED: begin
          if (!open_load_sense) begin
            ol_d = OL_IDLE;
            olflag_d = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      opt_q <= `OPT_RESET_VAL; // see R06
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      slew_q <= 1'b0;
      spread_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      opt_q <= opt_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      slew_q <= slew_d;
      spread_q <= spread_d;
      tick_q <= tick_d;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dis_q <= 1'b0;
      abe_q <= 1'b0;
      pins_seen_q <= 1'b0;
      tog_q <= 1'b0;
      copy_q <= 1'b0;
      hclr_q <= 1'b0;
      rclr_q <= 1'b0;
      diag2_q <= `DIAG_ALL_ONES;
    end else begin
      dis_q <= dis_d;
      abe_q <= abe_d;
      pins_seen_q <= pins_seen_d;
      tog_q <= tog_d;
      copy_q <= copy_d;
      hclr_q <= hclr_d;
      rclr_q <= rclr_d;
      diag2_q <= diag2_d;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ol_q <= OL_IDLE;
      olcnt_q <= '0;
      olflag_q <= 1'b0;
    end else begin
      ol_q <= ol_d;
      olcnt_q <= olcnt_d;
      olflag_q <= olflag_d;
    end
  end

  assign opt_read_data = rdata_q;
  assign opt_read_valid = rvalid_q;
  assign slew_fast = slew_q;
  assign spread_active = spread_q;
  assign sm_tick = tick_q;
  assign open_load_flag = olflag_q;
  assign stage_toggle_reset = tog_q;
  assign diag_copy = copy_q;
  assign second_diag_q = diag2_q;
  assign diag_history_reset = hclr_q;
  assign read_clear_reset = rclr_q;
endmodule

// ===== hw/bridge_option_consts.svh
// Constants for the bridge option register bank
`ifndef BRIDGE_OPTION_CONSTS_SVH
`define BRIDGE_OPTION_CONSTS_SVH
`define OPT_BIT_SPREAD 0
`define OPT_BIT_SLEW 2
`define OPT_BIT_OLFILT 4
`define OPT_WRITE_MASK 8'h15
`define OPT_RESET_VAL 8'h11
`define OL_FILTER_TIME_MS 40
`define CLK_FREQ_KHZ 125000
`define OL_FILTER_CYCLES (`OL_FILTER_TIME_MS * `CLK_FREQ_KHZ)
`define DIAG_ALL_ONES 4'hf
`define DITHER_SEED 8'h5a
`define SM_TICK_PERIOD 4'h8
`define SM_DITHER_MIN_PERIOD 4'h6
`endif

// ===== hw/bridge_option_pkg.sv
// Types for the bridge option register bank
package bridge_option_pkg;
  typedef enum logic [2:0] {
    OL_IDLE = 3'b001,
    OL_RETRY = 3'b010,
    OL_FLAGGED = 3'b100
  } ol_state_t;
  typedef logic [7:0] opt_reg_t;
endpackage

// ===== hw/clock_dither_if.sv
// Interface carrying the state machine clock enable and its dither control
`timescale 1ns/1ps
interface clock_dither_if;
  logic dither_on;
  logic tick;
  modport gen (input dither_on, output tick);
  modport use_side (output dither_on, input tick);
endinterface

// ===== hw/sm_tick_gen.sv
// Internal state machine tick generator, fixed or dithered period
`timescale 1ns/1ps
`include "bridge_option_consts.svh"
module sm_tick_gen (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Tick control
  clock_dither_if.gen dc
);
  logic [7:0] lfsr_q, lfsr_d;
  logic [3:0] cnt_q, cnt_d;
  logic tick_q, tick_d;
  logic [3:0] period;

  always_comb begin
    // Dither moves the period between 6 and 9 cycles; nominal 8
    if (dc.dither_on) begin // see R04
      period = `SM_DITHER_MIN_PERIOD + {2'b00, lfsr_q[1:0]};
    end else begin
      period = `SM_TICK_PERIOD; // see R05
    end
    lfsr_d = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    tick_d = 1'b0;
    cnt_d = cnt_q + 4'h1;
    if (cnt_q + 4'h1 >= period) begin
      cnt_d = 4'h0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lfsr_q <= `DITHER_SEED;
      cnt_q <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      lfsr_q <= lfsr_d;
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign dc.tick = tick_q;
endmodule

// ===== dv/opt_regs_sva.sv
// Port checker for the option register bank
`timescale 1ns/1ps
module opt_regs_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Commands
  input wire logic opt_write_cmd,
  input wire logic [7:0] opt_write_data,
  input wire logic opt_read_cmd,
  input wire logic software_reset_command,
  input wire logic diag_transfer_clear,
  input wire logic diag_history_clear,
  input wire logic read_access_reset,
  // Pins and sensing
  input wire logic stage_disable_pin,
  input wire logic stage_enable_low_pin,
  input wire logic supply_undervoltage,
  input wire logic bridge_active,
  input wire logic open_load_sense,
  input wire logic [3:0] first_diag_errors,
  // Watched outputs
  input wire logic [7:0] opt_read_data,
  input wire logic opt_read_valid,
  input wire logic slew_fast,
  input wire logic spread_active,
  input wire logic open_load_flag,
  input wire logic stage_toggle_reset,
  input wire logic diag_copy,
  input wire logic [3:0] second_diag_q,
  input wire logic diag_history_reset,
  input wire logic read_clear_reset
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  rd_zero_a: assert property (opt_read_valid |-> (opt_read_data & 8'hea) == 8'h00) else $error("rd bits");
  rd_answer_a: assert property (opt_read_cmd |=> opt_read_valid) else $error("rd late");
  slew_map_a: assert property (opt_write_cmd && !software_reset_command |-> ##2
    slew_fast == $past(opt_write_data[2], 2)) else $error("slew");
  spread_map_a: assert property (opt_write_cmd && !software_reset_command |-> ##2
    spread_active == $past(opt_write_data[0], 2)) else $error("spread");
  swr_value_a: assert property (software_reset_command |-> ##2 !slew_fast && spread_active) else $error("swr");
  pin_edge_a: assert property (!$past(rst) && (stage_disable_pin != $past(stage_disable_pin) ||
    stage_enable_low_pin != $past(stage_enable_low_pin)) |=> stage_toggle_reset) else $error("pin edge");
  diag_copy_a: assert property (diag_transfer_clear && !supply_undervoltage && !diag_history_clear &&
    !software_reset_command |=> diag_copy && second_diag_q == $past(first_diag_errors)) else $error("copy");
  uv_block_a: assert property (diag_transfer_clear && supply_undervoltage |=> !diag_copy) else $error("uv");
  hist_clear_a: assert property (diag_history_clear |=> diag_history_reset && second_diag_q == 4'hf)
    else $error("hist");
  ol_off_a: assert property (!bridge_active ##1 !bridge_active |-> open_load_flag == $past(open_load_sense))
    else $error("ol off");
  rd_reset_a: assert property (read_access_reset |=> read_clear_reset) else $error("read reset");
  cover property (opt_write_cmd && software_reset_command);
  cover property (diag_copy);
  cover property (open_load_flag && bridge_active);
  cover property (stage_toggle_reset);
endmodule
bind bridge_option_regs opt_regs_sva i_opt_regs_sva (
  .ref_clk(ref_clk), .rst(rst), .opt_write_cmd(opt_write_cmd), .opt_write_data(opt_write_data),
  .opt_read_cmd(opt_read_cmd), .software_reset_command(software_reset_command),
  .diag_transfer_clear(diag_transfer_clear), .diag_history_clear(diag_history_clear),
  .read_access_reset(read_access_reset), .stage_disable_pin(stage_disable_pin),
  .stage_enable_low_pin(stage_enable_low_pin), .supply_undervoltage(supply_undervoltage),
  .bridge_active(bridge_active), .open_load_sense(open_load_sense), .first_diag_errors(first_diag_errors),
  .opt_read_data(opt_read_data), .opt_read_valid(opt_read_valid), .slew_fast(slew_fast),
  .spread_active(spread_active), .open_load_flag(open_load_flag), .stage_toggle_reset(stage_toggle_reset),
  .diag_copy(diag_copy), .second_diag_q(second_diag_q), .diag_history_reset(diag_history_reset),
  .read_clear_reset(read_clear_reset)
);

// ===== dv/host_model.sv
// Host side model issuing option register commands
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic ref_clk,
  // Command strobes
  output logic opt_write_cmd,
  output logic [7:0] opt_write_data,
  output logic opt_read_cmd,
  output logic software_reset_command
);
  initial begin
    {opt_write_cmd, opt_read_cmd, software_reset_command} = 3'b000;
    opt_write_data = 8'h00;
  end
  // One strobe per frame; data is inverted once released so stale values never match
  task automatic cmd(input logic [2:0] c, input logic [7:0] v);
    @(posedge ref_clk);
    {opt_write_cmd, opt_read_cmd, software_reset_command} <= c;
    opt_write_data <= v;
    @(posedge ref_clk);
    {opt_write_cmd, opt_read_cmd, software_reset_command} <= 3'b000;
    opt_write_data <= ~v;
  endtask
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the option register bank
`timescale 1ns/1ps
module tb_top;
  import bridge_option_pkg::*;
  logic ref_clk = 0, rst = 1, diag_transfer_clear = 0, diag_history_clear = 0, read_access_reset = 0;
  logic stage_disable_pin = 0, stage_enable_low_pin = 1, supply_undervoltage = 0, bridge_active = 0;
  logic open_load_sense = 0, opt_write_cmd, opt_read_cmd, software_reset_command, opt_read_valid;
  logic slew_fast, spread_active, sm_tick, open_load_flag, stage_toggle_reset, diag_copy;
  logic diag_history_reset, read_clear_reset, odd;
  logic [3:0] first_diag_errors = 4'h0, second_diag_q;
  logic [7:0] opt_write_data, opt_read_data;
  opt_reg_t m, d, rd_expect[$];
  int err_total = 0, check_count = 0, seed = 32'h56553d3d, n, g;
  bridge_option_regs i_bridge_option_regs (
    .ref_clk(ref_clk), .rst(rst), .opt_write_cmd(opt_write_cmd), .opt_write_data(opt_write_data),
    .opt_read_cmd(opt_read_cmd), .software_reset_command(software_reset_command),
    .diag_transfer_clear(diag_transfer_clear), .diag_history_clear(diag_history_clear),
    .read_access_reset(read_access_reset), .stage_disable_pin(stage_disable_pin),
    .stage_enable_low_pin(stage_enable_low_pin), .supply_undervoltage(supply_undervoltage),
    .bridge_active(bridge_active), .open_load_sense(open_load_sense), .first_diag_errors(first_diag_errors),
    .opt_read_data(opt_read_data), .opt_read_valid(opt_read_valid), .slew_fast(slew_fast),
    .spread_active(spread_active), .sm_tick(sm_tick), .open_load_flag(open_load_flag),
    .stage_toggle_reset(stage_toggle_reset), .diag_copy(diag_copy), .second_diag_q(second_diag_q),
    .diag_history_reset(diag_history_reset), .read_clear_reset(read_clear_reset)
  );
  host_model i_host_model (
    .ref_clk(ref_clk), .opt_write_cmd(opt_write_cmd), .opt_write_data(opt_write_data),
    .opt_read_cmd(opt_read_cmd), .software_reset_command(software_reset_command)
  );
  initial forever #4 ref_clk = ~ref_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rd;
    rd_expect.push_back(m);
    i_host_model.cmd(3'b010, 8'h00);
    @(negedge ref_clk);
    chk(8'(opt_read_valid), 8'h01);
    chk(opt_read_data, rd_expect.pop_front());
  endtask
  task automatic wr(input opt_reg_t v);
    i_host_model.cmd(3'b100, v);
    m = v & 8'h15;
    repeat (2) @(negedge ref_clk);
    chk(8'(slew_fast), 8'(m[2]));
    chk(8'(spread_active), 8'(m[0]));
  endtask
  task automatic dg(input logic [3:0] c, input logic [3:0] e, input logic [3:0] x);
    @(posedge ref_clk);
    {diag_transfer_clear, diag_history_clear, supply_undervoltage, read_access_reset} <= c;
    first_diag_errors <= e;
    @(posedge ref_clk);
    {diag_transfer_clear, diag_history_clear, read_access_reset} <= 3'b000;
    @(negedge ref_clk);
    chk(8'(diag_copy), 8'(c[3] & ~c[1]));
    chk(8'(diag_history_reset), 8'(c[2]));
    chk(8'(read_clear_reset), 8'(c[0]));
    @(negedge ref_clk);
    chk(8'(second_diag_q), 8'(x));
  endtask
  task automatic ol(input opt_reg_t f, input logic a, input logic x);
    wr(f);
    @(posedge ref_clk);
    {bridge_active, open_load_sense} <= {a, 1'b1};
    repeat (4) @(negedge ref_clk);
    chk(8'(open_load_flag), 8'(x));
    @(posedge ref_clk);
    open_load_sense <= 0;
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic tk(input opt_reg_t f, input logic x);
    wr(f);
    {g, n, odd} = 0;
    repeat (200) begin
      @(negedge ref_clk);
      g++;
      if (sm_tick === 1'b1) begin
        if (n > 0 && g != 8) odd = 1;
        n++;
        g = 0;
      end
    end
    chk(8'(odd), 8'(x));
    chk(8'(n > 20), 8'h01);
  endtask
  initial begin
    m = 8'h11;
    repeat (4) @(posedge ref_clk);
    rst <= 0;
    rd;
    for (int k = 0; k < 6; k++) begin
      d = 8'($random(seed));
      wr(d);
      rd;
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      if (k == 0) stage_disable_pin <= 1;
      else stage_enable_low_pin <= 0;
      n = 0;
      repeat (6) begin
        @(negedge ref_clk);
        n += stage_toggle_reset;
      end
      chk(8'(n), 8'h01);
    end
    rd;
    // Reset and write in one cycle: reset must win
    i_host_model.cmd(3'b101, 8'h04);
    m = 8'h11;
    rd;
    chk(8'(slew_fast), 8'h00);
    dg(4'b1000, 4'h6, 4'h6);
    dg(4'b1010, 4'h9, 4'h6);
    dg(4'b0101, 4'h9, 4'hf);
    rd;
    ol(8'h00, 1'b1, 1'b0);
    ol(8'h00, 1'b0, 1'b1);
    ol(8'h10, 1'b1, 1'b1);
    tk(8'h00, 1'b0);
    tk(8'h01, 1'b1);
    results;
  end
  initial begin
    #200000;
    err_total++;
    results;
  end
endmodule
